// ### bench/vbc_cs_checker.sv
`include "vbc_defs.vh"

module vbc_cs_checker #(
    parameter [0:0] INH_RESV_INIT = 1'b1
) (
    // clock and reset
    input wire        clk_sys_i,
    input wire        sys_rst_i,
    // host port
    input wire [24:0] host_addr_i,
    input wire        host_wr_i,
    input wire        host_rd_i,
    input wire [31:0] host_rdata_o,
    input wire        host_ack_o,
    // status side
    input wire        unequip_err_set_i,
    input wire        reset_done_i,
    input wire [25:0] csr_o
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam [25:0] RST_CSR = 26'h2001010 | {6'h0, INH_RESV_INIT, 19'h0};
    wire req = host_wr_i | host_rd_i;
    // host write to the halt bit location
    wire wr_halt = host_wr_i && (host_addr_i == 25'h0010007);

    chk_ack_follows: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        req |=> host_ack_o) else $error("ack missing after request");
    chk_ack_only: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !req |=> !host_ack_o) else $error("ack without request");
    chk_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !host_rd_i |=> host_rdata_o == 32'h0) else $error("read data not idle");
    chk_csr_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        host_rd_i && host_addr_i == `VBC_CSR_BASE |=> host_rdata_o == {6'h0, $past(csr_o)})
        else $error("status word read wrong");
    chk_reset_value: assert property (@(posedge clk_sys_i)
        sys_rst_i |=> csr_o == RST_CSR) else $error("status reset value wrong");
    chk_intbuf_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        csr_o[25] |=> csr_o[25]) else $error("buffer enable dropped");
    chk_unequip_set: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        unequip_err_set_i |=> csr_o[24]) else $error("unequipped flag not set");
    chk_reset_done: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        reset_done_i && !host_wr_i |=> !csr_o[0]) else $error("reset control not cleared");
    chk_lvl10_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        csr_o[8] |=> csr_o[8]) else $error("level 10 cleared by program");
    chk_halt_prog: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $changed(csr_o[1]) |-> $past(wr_halt))
        else $error("halt changed without its write");

    cover property (@(posedge clk_sys_i) host_rd_i && host_addr_i == `VBC_SOFT_ACK_ADDR);
    cover property (@(posedge clk_sys_i) unequip_err_set_i && host_wr_i);
    cover property (@(posedge clk_sys_i) reset_done_i && csr_o[0]);
endmodule

bind vbc_ctrl_status vbc_cs_checker #(.INH_RESV_INIT(INH_RESV_INIT)) vbc_cs_checker_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .host_addr_i(host_addr_i),
    .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_rdata_o(host_rdata_o),
    .host_ack_o(host_ack_o), .unequip_err_set_i(unequip_err_set_i),
    .reset_done_i(reset_done_i), .csr_o(csr_o));

// ### bench/vbc_ctrl_status_tb_top.sv
`include "vbc_defs.vh"

module vbc_ctrl_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    wire  [24:0] addr;
    wire         wr;
    wire         rd;
    wire  [3:0]  be;
    wire  [31:0] wdata;
    wire  [31:0] rdata;
    wire         ack;
    logic [10:0] hw_ev = 11'h0;
    logic        reset_done = 1'b0;
    logic [7:0]  irq = 8'h0;
    logic        ld = 1'b0;
    logic [31:0] ld_val = 32'h1234ABCD;
    wire  [25:0] csr;
    wire         int_req;
    wire  [31:0] adr_lat;
    wire  [31:0] dat_lat;
    int          bad_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    logic [25:0] exp_csr;
    int pset[8] = '{20, 19, 17, 12, 8, 4, 1, 0};
    int hbit[11] = '{2, 3, 5, 6, 8, 14, 15, 16, 23, 24, 25};

    always #2 clk_sys_i = ~clk_sys_i;

    vbc_host_model vbc_host_model_i (.clk_sys_i(clk_sys_i), .host_addr_o(addr),
        .host_wr_o(wr), .host_rd_o(rd), .host_be_o(be), .host_wdata_o(wdata),
        .host_rdata_i(rdata), .host_ack_i(ack));

    vbc_ctrl_status #(.ID_CODE(8'h3C), .INH_RESV_INIT(1'b1)) vbc_ctrl_status_i (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .host_addr_i(addr), .host_wr_i(wr),
        .host_rd_i(rd), .host_be_i(be), .host_wdata_i(wdata), .host_rdata_o(rdata),
        .host_ack_o(ack), .intbuf_en_set_i(hw_ev[10]), .unequip_err_set_i(hw_ev[9]),
        .dir_fault_set_i(hw_ev[8]), .xfer_dir_set_i(hw_ev[7]), .remote_err_set_i(hw_ev[6]),
        .bp_fault_set_i(hw_ev[5]), .lvl10_set_i(hw_ev[4]), .data_par_set_i(hw_ev[3]),
        .addr_par_set_i(hw_ev[2]), .error_set_i(hw_ev[1]), .lvl15_set_i(hw_ev[0]),
        .reset_done_i(reset_done), .remote_irq_i(irq), .addr_latch_load_i(ld),
        .addr_latch_val_i(ld_val), .data_latch_load_i(ld), .data_latch_val_i(~ld_val),
        .csr_o(csr), .int_req_o(int_req), .address_latch_o(adr_lat), .data_latch_o(dat_lat));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [24:0] a, input logic [3:0] b, input logic [31:0] d);
        logic [31:0] q;
        logic        k;
        vbc_host_model_i.access(1'b1, a, b, d, q, k);
        check("write ack", {31'h0, k}, 32'h1);
    endtask

    task automatic rd_reg(input logic [24:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        k;
        vbc_host_model_i.access(1'b0, a, 4'hF, 32'h0, q, k);
        check("read ack", {31'h0, k}, 32'h1);
        check("read data", q, exp);
    endtask

    task automatic bit_wr(input int n, input logic v);
        wr_reg(`VBC_CSR_BASE + 25'(4 * n + 3), 4'h8, {7'h0, v, 24'h0});
    endtask

    task automatic pulse_hw_ev(input logic [10:0] v);
        @(negedge clk_sys_i);
        hw_ev = v;
        @(negedge clk_sys_i);
        hw_ev = 11'h0;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            complete_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        exp_csr = 26'h2081010;
        rd_reg(`VBC_CSR_BASE, {6'h0, exp_csr});
        foreach (pset[i]) begin
            bit_wr(pset[i], 1'b1);
            exp_csr[pset[i]] = 1'b1;
            check("bit set", {6'h0, csr}, {6'h0, exp_csr});
        end
        foreach (pset[i]) bit_wr(pset[i], 1'b0);
        exp_csr = exp_csr & ~26'h01A1012;
        rd_reg(`VBC_CSR_BASE, {6'h0, exp_csr});
        @(negedge clk_sys_i);
        reset_done = 1'b1;
        @(negedge clk_sys_i);
        reset_done = 1'b0;
        exp_csr[0] = 1'b0;
        check("reset control", {6'h0, csr}, {6'h0, exp_csr});
        wr_reg(25'h0010007, 4'hF, 32'h01000000);
        bit_wr(25, 1'b0);
        check("lane and bit 25", {6'h0, csr}, {6'h0, exp_csr});
        for (int i = 0; i < 11; i++) begin
            pulse_hw_ev(11'(1 << i));
            exp_csr[hbit[i]] = 1'b1;
            check("hardware set", {6'h0, csr}, {6'h0, exp_csr});
        end
        for (int i = 0; i < 10; i++) if (i != 4) bit_wr(hbit[i], 1'b0);
        exp_csr = 26'h2000100;
        rd_reg(`VBC_CSR_BASE, {6'h0, exp_csr});
        @(negedge clk_sys_i);
        hw_ev[9] = 1'b1;
        bit_wr(24, 1'b0);
        hw_ev[9] = 1'b0;
        check("set beats clear", {31'h0, csr[24]}, 32'h1);
        rd_reg(`VBC_ID_ADDR, 32'h0000003C);
        rd_reg(25'h0020000, 32'h0);
        wr_reg(`VBC_IMR_ADDR, 4'h1, 32'h0);
        @(negedge clk_sys_i);
        irq = 8'h08;
        @(negedge clk_sys_i);
        irq = 8'h00;
        check("int request", {31'h0, int_req}, 32'h1);
        rd_reg(`VBC_SOFT_ACK_ADDR, 32'h3);
        rd_reg(`VBC_ISR_ADDR, 32'h08);
        check("int request idle", {31'h0, int_req}, 32'h0);
        @(negedge clk_sys_i);
        irq = 8'h08;
        @(negedge clk_sys_i);
        irq = 8'h00;
        wr_reg(`VBC_CLR_CUR_ADDR, 4'h1, 32'h0);
        rd_reg(`VBC_IPR_ADDR, 32'h0);
        wr_reg(`VBC_IC_EOS_ADDR, 4'h1, 32'h0);
        rd_reg(`VBC_ISR_ADDR, 32'h0);
        wr_reg(`VBC_IC_MCLR_ADDR, 4'h1, 32'h0);
        rd_reg(`VBC_IMR_ADDR, 32'hFF);
        rd_reg(`VBC_SOFT_ACK_ADDR, 32'h80);
        @(negedge clk_sys_i);
        ld = 1'b1;
        @(negedge clk_sys_i);
        ld = 1'b0;
        check("address latch", adr_lat, 32'h1234ABCD);
        check("data latch", dat_lat, 32'hEDCB5432);
        wr_reg(`VBC_ADDR_LATCH_ADDR, 4'hF, 32'h5A5AC3C3);
        rd_reg(`VBC_ADDR_LATCH_ADDR, 32'h5A5AC3C3);
        wr_reg(`VBC_DATA_LATCH_ADDR, 4'hF, 32'h0F0F9696);
        rd_reg(`VBC_DATA_LATCH_ADDR, 32'h0F0F9696);
        // mid-run reset with bits 24 and 8 set and latches loaded
        @(negedge clk_sys_i);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        check("mid-run reset", {6'h0, csr}, 32'h02081010);
        check("latch reset", adr_lat | dat_lat, 32'h0);
        rd_reg(`VBC_CSR_BASE, 32'h02081010);
        complete_run;
    end
endmodule

// ### bench/vbc_host_model.sv
module vbc_host_model (
    // clock
    input  wire logic        clk_sys_i,
    // requests toward the block
    output logic      [24:0] host_addr_o,
    output logic             host_wr_o,
    output logic             host_rd_o,
    output logic      [3:0]  host_be_o,
    output logic      [31:0] host_wdata_o,
    // answers
    input  wire logic [31:0] host_rdata_i,
    input  wire logic        host_ack_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        host_addr_o = 25'h0;
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        host_be_o = 4'h0;
        host_wdata_o = 32'h0;
    end

    // one access, on the byte lanes given by the caller
    task automatic access(input logic w, input logic [24:0] a, input logic [3:0] b,
                          input logic [31:0] d, output logic [31:0] q, output logic k);
        @(negedge clk_sys_i);
        host_wr_o = w;
        host_rd_o = !w;
        host_addr_o = a;
        host_be_o = b;
        host_wdata_o = d;
        @(negedge clk_sys_i);
        q = host_rdata_i;
        k = host_ack_i;
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        // released lines show no stale value
        host_addr_o = ~a;
        host_be_o = ~b;
        host_wdata_o = ~d;
    endtask
endmodule

// ### rtl/vbc_csr_cell.v
`include "vbc_defs.vh"

module vbc_csr_cell #(
    parameter [0:0] HSET    = 1'b0,
    parameter [0:0] HCLR    = 1'b0,
    parameter [0:0] PSET    = 1'b0,
    parameter [0:0] PCLR    = 1'b0,
    parameter [0:0] RST_VAL = 1'b0
) (
    // clock and reset
    input  wire clk_sys_i,
    input  wire sys_rst_i,
    // hardware events
    input  wire hw_set_i,
    input  wire hw_clr_i,
    // program write to this bit's location
    input  wire wr_i,
    input  wire wr_val_i,
    // stored bit
    output reg  bit_o
);

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            bit_o <= RST_VAL;
        end else if (HSET && hw_set_i) begin
            bit_o <= 1'b1;
        end else if (HCLR && hw_clr_i) begin
            bit_o <= 1'b0;
        end else if (wr_i && wr_val_i && PSET) begin
            bit_o <= 1'b1;
        end else if (wr_i && !wr_val_i && PCLR) begin
            bit_o <= 1'b0;
        end
    end

endmodule

// ### rtl/vbc_ctrl_status.v
`include "vbc_defs.vh"

module vbc_ctrl_status #(
    parameter [7:0] ID_CODE       = 8'hA5, // arbitrary value
    parameter [0:0] INH_RESV_INIT = 1'b1
) (
    // clock and reset
    input  wire        clk_sys_i,
    input  wire        sys_rst_i,
    // host register port
    input  wire [24:0] host_addr_i,
    input  wire        host_wr_i,
    input  wire        host_rd_i,
    input  wire [3:0]  host_be_i,
    input  wire [31:0] host_wdata_i,
    output reg  [31:0] host_rdata_o,
    output reg         host_ack_o,
    // hardware set events
    input  wire        intbuf_en_set_i,
    input  wire        unequip_err_set_i,
    input  wire        dir_fault_set_i,
    input  wire        xfer_dir_set_i,
    input  wire        remote_err_set_i,
    input  wire        bp_fault_set_i,
    input  wire        lvl10_set_i,
    input  wire        data_par_set_i,
    input  wire        addr_par_set_i,
    input  wire        error_set_i,
    input  wire        lvl15_set_i,
    // hardware clear of the reset control
    input  wire        reset_done_i,
    // remote bus interrupt requests
    input  wire [7:0]  remote_irq_i,
    // hardware loads of the latches
    input  wire        addr_latch_load_i,
    input  wire [31:0] addr_latch_val_i,
    input  wire        data_latch_load_i,
    input  wire [31:0] data_latch_val_i,
    // control and state outputs
    output wire [25:0] csr_o,
    output reg         int_req_o,
    output reg  [31:0] address_latch_o,
    output reg  [31:0] data_latch_o
);

    ////////////////////////////////////////////////////////////////////////////

    localparam [25:0] HSET_M = `VBC_HSET_MASK;
    localparam [25:0] HCLR_M = `VBC_HCLR_MASK;
    localparam [25:0] PSET_M = `VBC_PSET_MASK;
    localparam [25:0] PCLR_M = `VBC_PCLR_MASK;
    localparam [25:0] IMPL_M = `VBC_IMPL_MASK;
    localparam [25:0] SRST_M = `VBC_SRST_MASK
                             | ({25'h0, INH_RESV_INIT} << `VBC_BIT_INH_RESV);

    // write location of one status bit, byte 3 of its word
    function [24:0] csr_bit_loc;
        input integer idx;
        reg [24:0] step;
        begin
            step = idx[24:0];
            csr_bit_loc = `VBC_CSR_BASE + step * `VBC_CSR_BIT_STEP
                        + `VBC_CSR_BYTE3;
        end
    endfunction

    // lowest index set bit wins, as a one-hot mask
    function [7:0] top_prio;
        input [7:0] v;
        begin
            top_prio = v & (~v + 8'h01);
        end
    endfunction

    // index of a one-hot mask
    function [2:0] prio_idx;
        input [7:0] oh;
        integer k;
        begin
            prio_idx = 3'h0;
            for (k = 0; k < 8; k = k + 1) begin
                if (oh[k]) begin
                    prio_idx = k[2:0];
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // control and status register

    wire [25:0] hw_set;
    wire [25:0] hw_clr;
    wire [25:0] csr_q;
    wire        csr_wr_ok;
    wire        csr_wr_val;

    assign hw_set = ({25'h0, intbuf_en_set_i}   << `VBC_BIT_INTBUF_EN)
                  | ({25'h0, unequip_err_set_i} << `VBC_BIT_UNEQUIP)
                  | ({25'h0, dir_fault_set_i}   << `VBC_BIT_DIR_FAULT)
                  | ({25'h0, xfer_dir_set_i}    << `VBC_BIT_XFER_DIR)
                  | ({25'h0, remote_err_set_i}  << `VBC_BIT_REM_ERR)
                  | ({25'h0, bp_fault_set_i}    << `VBC_BIT_BP_FAULT)
                  | ({25'h0, lvl10_set_i}       << `VBC_BIT_LVL10)
                  | ({25'h0, data_par_set_i}    << `VBC_BIT_DATA_PAR)
                  | ({25'h0, addr_par_set_i}    << `VBC_BIT_ADDR_PAR)
                  | ({25'h0, error_set_i}       << `VBC_BIT_ERROR)
                  | ({25'h0, lvl15_set_i}       << `VBC_BIT_LVL15);

    assign hw_clr = {25'h0, reset_done_i};

    // only a byte write on lane 3 may touch a status bit
    assign csr_wr_ok  = host_wr_i && (host_be_i == `VBC_LANE3_ONLY);
    assign csr_wr_val = host_wdata_i[`VBC_CSR_VAL_BIT];

    genvar g;
    generate
        for (g = 0; g < `VBC_CSR_W; g = g + 1) begin : g_csr
            if (IMPL_M[g]) begin : g_bit
                wire hit;
                // bit 25 has no write location
                assign hit = csr_wr_ok && (g != `VBC_BIT_INTBUF_EN)
                          && (host_addr_i == csr_bit_loc(g));
                vbc_csr_cell #(
                    .HSET    (HSET_M[g]),
                    .HCLR    (HCLR_M[g]),
                    .PSET    (PSET_M[g]),
                    .PCLR    (PCLR_M[g]),
                    .RST_VAL (SRST_M[g])
                ) u_cell (
                    .clk_sys_i (clk_sys_i),
                    .sys_rst_i (sys_rst_i),
                    .hw_set_i  (hw_set[g]),
                    .hw_clr_i  (hw_clr[g]),
                    .wr_i      (hit),
                    .wr_val_i  (csr_wr_val),
                    .bit_o     (csr_q[g])
                );
            end else begin : g_rsvd
                assign csr_q[g] = 1'b0;
            end
        end
    endgenerate

    assign csr_o = csr_q;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    wire wr_mclr;
    wire wr_eos;
    wire wr_imr;
    wire wr_isr;
    wire wr_ipr;
    wire wr_clr_cur;
    wire wr_addr_latch;
    wire wr_data_latch;
    wire rd_ack;

    assign wr_mclr = host_wr_i && (host_addr_i == `VBC_IC_MCLR_ADDR);
    assign wr_eos  = host_wr_i && (host_addr_i == `VBC_IC_EOS_ADDR);
    assign wr_imr  = host_wr_i && (host_addr_i == `VBC_IMR_ADDR) && host_be_i[0];
    assign wr_isr  = host_wr_i && (host_addr_i == `VBC_ISR_ADDR) && host_be_i[0];
    assign wr_ipr  = host_wr_i && (host_addr_i == `VBC_IPR_ADDR) && host_be_i[0];
    assign wr_clr_cur    = host_wr_i && (host_addr_i == `VBC_CLR_CUR_ADDR);
    assign wr_addr_latch = host_wr_i && (host_addr_i == `VBC_ADDR_LATCH_ADDR);
    assign wr_data_latch = host_wr_i && (host_addr_i == `VBC_DATA_LATCH_ADDR);
    assign rd_ack  = host_rd_i && (host_addr_i == `VBC_SOFT_ACK_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // interrupt controller

    reg  [7:0] interrupt_mask;
    reg  [7:0] interrupt_in_service;
    reg  [7:0] interrupt_pending;
    reg  [7:0] next_imr;
    reg  [7:0] next_isr;
    reg  [7:0] next_ipr;
    wire [7:0] live;
    wire [7:0] ack_oh;
    wire [7:0] isr_top;

    assign live    = interrupt_pending & ~interrupt_mask;
    assign ack_oh  = top_prio(live);
    assign isr_top = top_prio(interrupt_in_service);

    always @* begin
        next_imr = interrupt_mask;
        next_isr = interrupt_in_service;
        next_ipr = interrupt_pending;
        if (wr_mclr) begin
            next_imr = `VBC_IMR_RST;
            next_isr = 8'h00;
            next_ipr = 8'h00;
        end
        if (wr_imr) begin
            next_imr = host_wdata_i[7:0];
        end
        if (wr_isr) begin
            next_isr = host_wdata_i[7:0];
        end
        if (wr_ipr) begin
            next_ipr = host_wdata_i[7:0];
        end
        if (wr_eos) begin
            next_isr = interrupt_in_service & ~isr_top;
        end
        if (wr_clr_cur) begin
            next_ipr = interrupt_pending & ~isr_top;
        end
        if (rd_ack) begin
            next_ipr = next_ipr & ~ack_oh;
            next_isr = next_isr | ack_oh;
        end
        // a request arriving during a clear is kept
        next_ipr = next_ipr | remote_irq_i;
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            interrupt_mask       <= `VBC_IMR_RST;
            interrupt_in_service       <= 8'h00;
            interrupt_pending       <= 8'h00;
            int_req_o <= 1'b0;
        end else begin
            interrupt_mask       <= next_imr;
            interrupt_in_service       <= next_isr;
            interrupt_pending       <= next_ipr;
            int_req_o <= |(next_ipr & ~next_imr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address and data latches

    integer b;

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            address_latch_o <= 32'h00000000;
            data_latch_o    <= 32'h00000000;
        end else begin
            if (addr_latch_load_i) begin
                address_latch_o <= addr_latch_val_i;
            end else if (wr_addr_latch) begin
                for (b = 0; b < 4; b = b + 1) begin
                    if (host_be_i[b]) begin
                        address_latch_o[8*b +: 8] <= host_wdata_i[8*b +: 8];
                    end
                end
            end
            if (data_latch_load_i) begin
                data_latch_o <= data_latch_val_i;
            end else if (wr_data_latch) begin
                for (b = 0; b < 4; b = b + 1) begin
                    if (host_be_i[b]) begin
                        data_latch_o[8*b +: 8] <= host_wdata_i[8*b +: 8];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    reg [31:0] next_rdata;

    always @* begin
        next_rdata = 32'h00000000;
        case (host_addr_i)
            `VBC_CSR_BASE: begin
                next_rdata = {6'h00, csr_q};
            end
            `VBC_ID_ADDR: begin
                next_rdata = {24'h000000, ID_CODE};
            end
            `VBC_IMR_ADDR: begin
                next_rdata = {24'h000000, interrupt_mask};
            end
            `VBC_ISR_ADDR: begin
                next_rdata = {24'h000000, interrupt_in_service};
            end
            `VBC_IPR_ADDR: begin
                next_rdata = {24'h000000, interrupt_pending};
            end
            `VBC_SOFT_ACK_ADDR: begin
                if (|live) begin
                    next_rdata = {29'h00000000, prio_idx(ack_oh)};
                end else begin
                    next_rdata = {24'h000000, `VBC_ACK_NONE};
                end
            end
            `VBC_ADDR_LATCH_ADDR: begin
                next_rdata = address_latch_o;
            end
            `VBC_DATA_LATCH_ADDR: begin
                next_rdata = data_latch_o;
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // every access, mapped or not, is answered next cycle
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            host_rdata_o <= 32'h00000000;
            host_ack_o   <= 1'b0;
        end else begin
            host_ack_o <= host_rd_i || host_wr_i;
            if (host_rd_i) begin
                host_rdata_o <= next_rdata;
            end else begin
                host_rdata_o <= 32'h00000000;
            end
        end
    end

endmodule

// ### rtl/vbc_defs.vh
`ifndef VBC_DEFS_VH
`define VBC_DEFS_VH

// host address map, byte addresses
`define VBC_ADDR_W          25
`define VBC_CSR_BASE        25'h0010000
`define VBC_CSR_LAST        25'h001007F
`define VBC_ID_ADDR         25'h0014000
`define VBC_IC_MCLR_ADDR    25'h0040000
`define VBC_IC_EOS_ADDR     25'h0040004
`define VBC_IMR_ADDR        25'h0041000
`define VBC_ISR_ADDR        25'h0042000
`define VBC_IPR_ADDR        25'h0043000
`define VBC_SOFT_ACK_ADDR   25'h0044000
`define VBC_ADDR_LATCH_ADDR 25'h0050000
`define VBC_DATA_LATCH_ADDR 25'h0052000
`define VBC_CLR_CUR_ADDR    25'h0062000

// control and status register layout
`define VBC_CSR_W           26
`define VBC_CSR_BIT_STEP    25'h0000004
`define VBC_CSR_BYTE3       25'h0000003
`define VBC_CSR_VAL_BIT     24
`define VBC_LANE3_ONLY      4'h8

`define VBC_BIT_INTBUF_EN   25
`define VBC_BIT_UNEQUIP     24
`define VBC_BIT_DIR_FAULT   23
`define VBC_BIT_REQ_LOCK    20
`define VBC_BIT_INH_RESV    19
`define VBC_BIT_REM_RESET   17
`define VBC_BIT_XFER_DIR    16
`define VBC_BIT_REM_ERR     15
`define VBC_BIT_BP_FAULT    14
`define VBC_BIT_INH_PAR     12
`define VBC_BIT_LVL10       8
`define VBC_BIT_DATA_PAR    6
`define VBC_BIT_ADDR_PAR    5
`define VBC_BIT_INH_ERR     4
`define VBC_BIT_ERROR       3
`define VBC_BIT_LVL15       2
`define VBC_BIT_HALT        1
`define VBC_BIT_RESET       0

// per-bit control capability masks
`define VBC_HSET_MASK       26'h381C16C
`define VBC_HCLR_MASK       26'h0000001
`define VBC_PSET_MASK       26'h01A1113
`define VBC_PCLR_MASK       26'h19BD07E
`define VBC_SRST_MASK       26'h2001010
`define VBC_IMPL_MASK       26'h39BD17F

// interrupt controller
`define VBC_IC_W            8
`define VBC_IMR_RST         8'hFF
`define VBC_ACK_NONE        8'h80

`endif
